// ---- hw/atpwm_top.sv ----
// analog-to-pulse-width modulator with AXI4-Lite registers
//
// Behaviour
// - a rising edge of enable starts the modulator.
// - working value is analog input times gain plus offset.
// - output is high for (working - low)/(high - low) of each period inside the range.
// - output is low for the rest of each period.
// - the pattern repeats back to back while enable stays high.
// - period comes from a register or a live input, with a selectable time base.
// - the decimals setting is only stored and read back, and never affects the output.
//
// Register access over AXI4-Lite and the register addresses are this design's own decisions.
`timescale 1ns/10ps
module atpwm_top
    import atpwm_pkg::*;
#(
    parameter int unsigned T_10MS = TICK_10MS,
    parameter int unsigned T_SEC  = TICK_SEC,
    parameter int unsigned T_MIN  = TICK_MIN,
    parameter longint unsigned T_HOUR = TICK_HOUR
)
(
    input  wire logic               aclk,
    input  wire logic               aresetn,
    input  wire logic               enable,
    input  wire logic signed [15:0] analog_in,
    input  wire logic        [15:0] period_live,
    output logic                    pulse_out,
    input  wire logic [ADDR_W-1:0]  s_axi_awaddr,
    input  wire logic               s_axi_awvalid,
    output logic                    s_axi_awready,
    input  wire logic [31:0]        s_axi_wdata,
    input  wire logic [3:0]         s_axi_wstrb,
    input  wire logic               s_axi_wvalid,
    output logic                    s_axi_wready,
    output logic [1:0]              s_axi_bresp,
    output logic                    s_axi_bvalid,
    input  wire logic               s_axi_bready,
    input  wire logic [ADDR_W-1:0]  s_axi_araddr,
    input  wire logic               s_axi_arvalid,
    output logic                    s_axi_arready,
    output logic [31:0]             s_axi_rdata,
    output logic [1:0]              s_axi_rresp,
    output logic                    s_axi_rvalid,
    input  wire logic               s_axi_rready
);
    // ---------------- register slave ----------------
    logic [31:0]       ctrl_r, ctrl_nxt, gain_r, gain_nxt, offs_r, offs_nxt;
    logic [31:0]       rlow_r, rlow_nxt, rhigh_r, rhigh_nxt, per_r, per_nxt;
    logic [ADDR_W-1:0] awaddr_r, awaddr_nxt;
    logic [31:0]       wdata_r, wdata_nxt;
    logic [3:0]        wstrb_r, wstrb_nxt;
    logic              aw_r, aw_nxt, w_r, w_nxt, bvalid_r, bvalid_nxt;
    logic [1:0]        bresp_r, bresp_nxt, rresp_r, rresp_nxt;
    logic              rvalid_r, rvalid_nxt;
    logic [31:0]       rdata_r, rdata_nxt;
    logic              do_wr;

    logic signed [31:0] working_r, working_nxt;
    atpwm_state_e       state_r, state_nxt;
    logic               en_s;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                          input logic [3:0] be);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++)
            if (be[i])
                res[i*8 +: 8] = d[i*8 +: 8];
        return res;
    endfunction

    always_comb
    begin
        aw_nxt     = aw_r;
        w_nxt      = w_r;
        awaddr_nxt = awaddr_r;
        wdata_nxt  = wdata_r;
        wstrb_nxt  = wstrb_r;
        bvalid_nxt = bvalid_r;
        bresp_nxt  = bresp_r;
        ctrl_nxt   = ctrl_r;
        gain_nxt   = gain_r;
        offs_nxt   = offs_r;
        rlow_nxt   = rlow_r;
        rhigh_nxt  = rhigh_r;
        per_nxt    = per_r;
        if (s_axi_awvalid && s_axi_awready)
        begin
            aw_nxt     = 1'b1;
            awaddr_nxt = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            w_nxt     = 1'b1;
            wdata_nxt = s_axi_wdata;
            wstrb_nxt = s_axi_wstrb;
        end
        do_wr = aw_r && w_r && !bvalid_r;
        if (do_wr)
        begin
            aw_nxt     = 1'b0;
            w_nxt      = 1'b0;
            bvalid_nxt = 1'b1;
            bresp_nxt  = RESP_OKAY;
            case (awaddr_r)
                ADDR_CTRL:   ctrl_nxt  = merge(ctrl_r, wdata_r, wstrb_r);
                ADDR_GAIN:   gain_nxt  = merge(gain_r, wdata_r, wstrb_r);
                ADDR_OFFSET: offs_nxt  = merge(offs_r, wdata_r, wstrb_r);
                ADDR_RLOW:   rlow_nxt  = merge(rlow_r, wdata_r, wstrb_r);
                ADDR_RHIGH:  rhigh_nxt = merge(rhigh_r, wdata_r, wstrb_r);
                ADDR_PERIOD: per_nxt   = merge(per_r, wdata_r, wstrb_r);
                ADDR_STATUS, ADDR_WORKING: bresp_nxt = RESP_OKAY;
                default:     bresp_nxt = RESP_SLVERR;
            endcase
        end
        if (bvalid_r && s_axi_bready)
            bvalid_nxt = 1'b0;
    end

    always_comb
    begin
        rvalid_nxt = rvalid_r;
        rdata_nxt  = rdata_r;
        rresp_nxt  = rresp_r;
        if (s_axi_arvalid && s_axi_arready)
        begin
            rvalid_nxt = 1'b1;
            rresp_nxt  = RESP_OKAY;
            case (s_axi_araddr)
                ADDR_CTRL:    rdata_nxt = ctrl_r;
                ADDR_GAIN:    rdata_nxt = gain_r;
                ADDR_OFFSET:  rdata_nxt = offs_r;
                ADDR_RLOW:    rdata_nxt = rlow_r;
                ADDR_RHIGH:   rdata_nxt = rhigh_r;
                ADDR_PERIOD:  rdata_nxt = per_r;
                ADDR_STATUS:  rdata_nxt = {28'h0, state_r, en_s, pulse_out};
                ADDR_WORKING: rdata_nxt = working_r;
                default:
                begin
                    rdata_nxt = 32'h0;
                    rresp_nxt = RESP_SLVERR;
                end
            endcase
        end
        else if (rvalid_r && s_axi_rready)
            rvalid_nxt = 1'b0;
    end

    assign s_axi_awready = !aw_r;
    assign s_axi_wready  = !w_r;
    assign s_axi_arready = !rvalid_r;
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rdata   = rdata_r;
    assign s_axi_rresp   = rresp_r;

    // ---------------- modulator ----------------
    logic              en_d_r, en_d_nxt, rise, unit_tick, out_r, out_nxt;
    logic [31:0]       pos_r, pos_nxt, hi_r, hi_nxt, len_r, len_nxt;
    logic signed [63:0] prod, num, den;
    logic [31:0]       per_sel;

    atpwm_sync u_en_sync
    (
        .aclk    (aclk),
        .aresetn (aresetn),
        .d       (enable),
        .q       (en_s)
    );

    atpwm_tick #(
        .T_10MS (T_10MS),
        .T_SEC  (T_SEC),
        .T_MIN  (T_MIN),
        .T_HOUR (T_HOUR)
    ) u_tick
    (
        .aclk    (aclk),
        .aresetn (aresetn),
        .restart (state_r != ST_RUN),
        .sel     (ctrl_r[CTRL_TB_LSB +: 2]),
        .tick    (unit_tick)
    );

    // decimals field is stored only; nothing below reads it
    always_comb
    begin
        rise    = en_s && !en_d_r;
        en_d_nxt = en_s;
        per_sel = ctrl_r[CTRL_PSRC_BIT] ? {16'h0, period_live} : per_r;
        if (per_sel == 32'h0)
            per_sel = 32'h1;
        // gain in hundredths, so the product is scaled back down
        prod = 64'(analog_in) * 64'(signed'(gain_r));
        working_nxt = 32'(prod / 64'(GAIN_SCALE) + 64'(signed'(offs_r)));
        num  = 64'(working_r) - 64'(signed'(rlow_r));
        den  = 64'(signed'(rhigh_r)) - 64'(signed'(rlow_r));
        state_nxt = state_r;
        pos_nxt   = pos_r;
        hi_nxt    = hi_r;
        len_nxt   = len_r;
        out_nxt   = 1'b0;
        case (state_r)
            ST_IDLE:
                if (rise)
                    state_nxt = ST_CALC;
            ST_CALC:
            begin
                // duty latched once per period so mid-period edits stay glitch free
                len_nxt = per_sel;
                pos_nxt = 32'h0;
                if (working_r <= signed'(rlow_r) || den <= 64'sh0)
                    hi_nxt = 32'h0;
                else if (working_r >= signed'(rhigh_r))
                    hi_nxt = per_sel;
                else
                    hi_nxt = 32'((num * 64'(per_sel)) / den);
                state_nxt = ST_RUN;
                // first run cycle already shows the duty, so full duty never dips
                out_nxt   = (hi_nxt != 32'h0);
            end
            ST_RUN:
            begin
                out_nxt = (pos_r < hi_r);
                if (unit_tick)
                begin
                    if (pos_r + 32'h1 >= len_r)
                    begin
                        state_nxt = ST_CALC;
                        out_nxt   = 1'b0;
                        pos_nxt   = pos_r;
                        if (hi_r >= len_r)
                            out_nxt = 1'b1;
                    end
                    else
                    begin
                        pos_nxt = pos_r + 32'h1;
                        out_nxt = (pos_r + 32'h1 < hi_r);
                    end
                end
            end
            default: state_nxt = ST_IDLE;
        endcase
        if (!en_s)
        begin
            state_nxt = ST_IDLE;
            out_nxt   = 1'b0;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ctrl_r <= RST_CTRL; gain_r <= RST_GAIN; offs_r <= RST_OFFSET;
            rlow_r <= RST_RLOW; rhigh_r <= RST_RHIGH; per_r <= RST_PERIOD;
            aw_r <= 1'b0; w_r <= 1'b0; awaddr_r <= '0; wdata_r <= 32'h0;
            wstrb_r <= 4'h0; bvalid_r <= 1'b0; bresp_r <= RESP_OKAY;
            rvalid_r <= 1'b0; rdata_r <= 32'h0; rresp_r <= RESP_OKAY;
            state_r <= ST_IDLE; en_d_r <= 1'b0; pos_r <= 32'h0;
            hi_r <= 32'h0; len_r <= 32'h1; out_r <= 1'b0; working_r <= 32'sh0;
        end
        else
        begin
            ctrl_r <= ctrl_nxt; gain_r <= gain_nxt; offs_r <= offs_nxt;
            rlow_r <= rlow_nxt; rhigh_r <= rhigh_nxt; per_r <= per_nxt;
            aw_r <= aw_nxt; w_r <= w_nxt; awaddr_r <= awaddr_nxt; wdata_r <= wdata_nxt;
            wstrb_r <= wstrb_nxt; bvalid_r <= bvalid_nxt; bresp_r <= bresp_nxt;
            rvalid_r <= rvalid_nxt; rdata_r <= rdata_nxt; rresp_r <= rresp_nxt;
            state_r <= state_nxt; en_d_r <= en_d_nxt; pos_r <= pos_nxt;
            hi_r <= hi_nxt; len_r <= len_nxt; out_r <= out_nxt; working_r <= working_nxt;
        end
    end

    assign pulse_out = out_r;

    // ---------------- assertions ----------------
    sequence s_rise;
        en_s && !en_d_r && state_r == ST_IDLE;
    endsequence
    sequence s_start;
        state_r == ST_CALC ##1 state_r == ST_RUN;
    endsequence

    a_start_on_rise: assert property (@(posedge aclk) disable iff (!aresetn)
        s_rise |=> s_start)
        else $error("enable rise did not start a period");
    a_idle_low_out: assert property (@(posedge aclk) disable iff (!aresetn)
        !en_s |=> !pulse_out && state_r == ST_IDLE)
        else $error("output not low while disabled");
    a_low_at_min: assert property (@(posedge aclk) disable iff (!aresetn)
        state_r == ST_RUN && hi_r == 32'h0 |-> !pulse_out)
        else $error("output high with zero duty");
    a_duty_tail_low: assert property (@(posedge aclk) disable iff (!aresetn)
        state_r == ST_RUN && $past(state_r) == ST_RUN && pos_r >= hi_r
        && $past(pos_r) == pos_r && en_s |-> !pulse_out)
        else $error("output high after duty portion");
    a_duty_head_high: assert property (@(posedge aclk) disable iff (!aresetn)
        state_r == ST_RUN && en_s && pos_r < hi_r && !unit_tick |=> pulse_out || !en_s)
        else $error("output low inside duty portion");
    a_period_repeat: assert property (@(posedge aclk) disable iff (!aresetn)
        state_r == ST_RUN && unit_tick && pos_r + 32'h1 >= len_r && en_s
        |=> state_r == ST_CALC)
        else $error("period did not restart");
    a_working_calc: assert property (@(posedge aclk) disable iff (!aresetn)
        $stable(analog_in) && $stable(gain_r) && $stable(offs_r)
        |=> working_r == 32'((64'($past(analog_in)) * 64'(signed'($past(gain_r))))
        / 64'(GAIN_SCALE) + 64'(signed'($past(offs_r)))))
        else $error("working value mismatch");
    a_full_duty_high: assert property (@(posedge aclk) disable iff (!aresetn)
        state_r == ST_CALC && en_s && working_r >= signed'(rhigh_r)
        && signed'(rhigh_r) > signed'(rlow_r) |=> pulse_out)
        else $error("output not high at full duty");
endmodule

// ---- hw/atpwm_pkg.sv ----
// shared constants for the analog-to-pulse-width modulator
package atpwm_pkg;
    localparam int unsigned CLK_HZ        = 10000000;
    localparam int unsigned DATA_W        = 32;
    localparam int unsigned ADDR_W        = 6;
    // register byte addresses
    localparam logic [ADDR_W-1:0] ADDR_CTRL     = 6'h00;
    localparam logic [ADDR_W-1:0] ADDR_GAIN     = 6'h04;
    localparam logic [ADDR_W-1:0] ADDR_OFFSET   = 6'h08;
    localparam logic [ADDR_W-1:0] ADDR_RLOW     = 6'h0c;
    localparam logic [ADDR_W-1:0] ADDR_RHIGH    = 6'h10;
    localparam logic [ADDR_W-1:0] ADDR_PERIOD   = 6'h14;
    localparam logic [ADDR_W-1:0] ADDR_STATUS   = 6'h18;
    localparam logic [ADDR_W-1:0] ADDR_WORKING  = 6'h1c;
    // ctrl fields
    localparam int unsigned CTRL_PSRC_BIT  = 0;
    localparam int unsigned CTRL_TB_LSB    = 1;
    localparam int unsigned CTRL_DEC_LSB   = 3;
    // reset values
    localparam logic [31:0] RST_CTRL    = 32'h0000_0000;
    localparam logic [31:0] RST_GAIN    = 32'h0000_0064;
    localparam logic [31:0] RST_OFFSET  = 32'h0000_0000;
    localparam logic [31:0] RST_RLOW    = 32'h0000_0000;
    localparam logic [31:0] RST_RHIGH   = 32'h0000_03e8;
    localparam logic [31:0] RST_PERIOD  = 32'h0000_0004;
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;
    // gain carries two fractional decimals
    localparam int signed   GAIN_SCALE  = 100;
    // time base units
    localparam int unsigned TB_10MS_NS  = 10000000;
    localparam int unsigned TB_SEC_NS   = 1000000000;
    localparam int unsigned CLK_NS      = 100;
    localparam int unsigned TICK_10MS   = TB_10MS_NS / CLK_NS;
    localparam int unsigned TICK_SEC    = TB_SEC_NS / CLK_NS;
    localparam int unsigned TICK_MIN    = 60 * TICK_SEC;
    // an hour of 100 ns ticks does not fit in 32 bits
    localparam longint unsigned TICK_HOUR = 64'(60) * 64'(TICK_MIN);
    typedef enum logic [1:0]
    {
        TB_10MS = 2'b00,
        TB_SEC  = 2'b01,
        TB_MIN  = 2'b10,
        TB_HOUR = 2'b11
    } atpwm_tb_e;
    typedef enum logic [1:0]
    {
        ST_IDLE = 2'b00,
        ST_CALC = 2'b01,
        ST_RUN  = 2'b10
    } atpwm_state_e;
endpackage

// ---- hw/atpwm_sync.sv ----
// two-flop synchroniser for one level
`timescale 1ns/10ps
module atpwm_sync
    import atpwm_pkg::*;
(
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic d,
    output logic      q
);
    logic meta_r;
    logic meta_nxt;
    logic q_r;
    logic q_nxt;

    always_comb
    begin
        meta_nxt = d;
        q_nxt    = meta_r;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            meta_r <= 1'b0;
            q_r    <= 1'b0;
        end
        else
        begin
            meta_r <= meta_nxt;
            q_r    <= q_nxt;
        end
    end

    assign q = q_r;
endmodule

// ---- hw/atpwm_tick.sv ----
// time-base prescaler: one pulse per unit of the selected base
`timescale 1ns/10ps
module atpwm_tick
    import atpwm_pkg::*;
#(
    parameter int unsigned T_10MS = TICK_10MS,
    parameter int unsigned T_SEC  = TICK_SEC,
    parameter int unsigned T_MIN  = TICK_MIN,
    parameter longint unsigned T_HOUR = TICK_HOUR
)
(
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       restart,
    input  wire logic [1:0] sel,
    output logic            tick
);
    logic [35:0] cnt_r;
    logic [35:0] cnt_nxt;
    logic [35:0] limit;

    always_comb
    begin
        case (sel)
            TB_10MS: limit = 36'(T_10MS);
            TB_SEC:  limit = 36'(T_SEC);
            TB_MIN:  limit = 36'(T_MIN);
            TB_HOUR: limit = 36'(T_HOUR);
            default: limit = 36'(T_SEC);
        endcase
        tick    = (cnt_r >= limit - 36'h1);
        cnt_nxt = (restart || tick) ? 36'h0 : cnt_r + 36'h1;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            cnt_r <= 36'h0;
        else
            cnt_r <= cnt_nxt;
    end
endmodule

// ---- verif/atpwm_src_model.sv ----
// upstream source model: analog value and live period feeding the modulator
`timescale 1ns/10ps
module atpwm_src_model
(
    input  wire logic               aclk,
    input  wire logic               set_v,
    input  wire logic signed [15:0] set_a,
    input  wire logic        [15:0] set_p,
    output logic signed [15:0]      analog_in,
    output logic        [15:0]      period_live
);
    initial
    begin
        analog_in   = 16'h0000;
        period_live = 16'h0000;
    end

    // values move only on request, like another function's actual value
    always @(posedge aclk)
    begin
        if (set_v)
        begin
            analog_in   <= set_a;
            period_live <= set_p;
        end
    end
endmodule

// ---- verif/tb_top.sv ----
// self-checking testbench for the analog-to-pulse-width modulator
`timescale 1ns/10ps
module tb_top
    import atpwm_pkg::*;
;
    localparam int unsigned T0 = 4;
    localparam int unsigned T1 = 6;
    localparam int unsigned T2 = 8;
    localparam int unsigned T3 = 10;
    logic               aclk = 1'b0;
    logic               aresetn = 1'b0;
    logic               enable = 1'b0;
    logic signed [15:0] analog_in;
    logic        [15:0] period_live;
    logic               pulse_out;
    logic [5:0]         awaddr = 6'h00;
    logic               awvalid = 1'b0;
    logic               awready;
    logic [31:0]        wdata = 32'h0;
    logic               wvalid = 1'b0;
    logic               wready;
    logic [1:0]         bresp;
    logic               bvalid;
    logic               bready = 1'b0;
    logic [5:0]         araddr = 6'h00;
    logic               arvalid = 1'b0;
    logic               arready;
    logic [31:0]        rdata;
    logic [1:0]         rresp;
    logic               rvalid;
    logic               rready = 1'b0;
    logic               set_v = 1'b0;
    logic signed [15:0] set_a = 16'h0;
    logic [15:0]        set_p = 16'h0;
    int                 err_total = 0;
    int                 samples_checked = 0;
    logic [31:0]        pq[$];
    logic [33:0]        rq[$];
    logic [1:0]         bq[$];
    logic [33:0]        re;
    logic [31:0]        hcnt = 32'h0;
    logic               prev_p = 1'b0;
    logic [5:0]         ra[6] = '{ADDR_CTRL, ADDR_GAIN, ADDR_OFFSET, ADDR_RLOW, ADDR_RHIGH,
                                  ADDR_PERIOD};
    logic [31:0]        rv[6] = '{RST_CTRL, RST_GAIN, RST_OFFSET, RST_RLOW, RST_RHIGH,
                                  RST_PERIOD};

    always #50 aclk = ~aclk;

    atpwm_src_model u_atpwm_src_model (.aclk(aclk), .set_v(set_v), .set_a(set_a),
        .set_p(set_p), .analog_in(analog_in), .period_live(period_live));

    atpwm_top #(.T_10MS(T0), .T_SEC(T1), .T_MIN(T2), .T_HOUR(T3)) u_atpwm_top (
        .aclk(aclk), .aresetn(aresetn), .enable(enable), .analog_in(analog_in),
        .period_live(period_live), .pulse_out(pulse_out),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready));

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            err_total++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // handshakes are judged at the falling edge, where every ready has settled
    always @(negedge aclk)
    begin
        if (rvalid === 1'b1 && rready && rq.size() > 0)
        begin
            re = rq.pop_front();
            check("rdata", rdata, re[31:0]);
            check("rresp", {30'h0, rresp}, {30'h0, re[33:32]});
        end
        if (bvalid === 1'b1 && bready && bq.size() > 0)
            check("bresp", {30'h0, bresp}, {30'h0, bq.pop_front()});
        if (prev_p === 1'b1 && pulse_out !== 1'b1 && pq.size() > 0)
            check("high_cycles", hcnt, pq.pop_front());
        hcnt = (pulse_out === 1'b1) ? hcnt + 1 : 32'h0;
        prev_p = pulse_out;
    end

    task automatic axi_wr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] e);
        int   n;
        logic ah;
        logic wh;
        logic bh;
        bq.push_back(e);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= d;
        wvalid <= 1'b1;
        bready <= 1'b1;
        ah = 1'b0;
        wh = 1'b0;
        bh = 1'b0;
        for (n = 0; n < 50 && !bh; n++)
        begin
            @(negedge aclk);
            if (awready === 1'b1) ah = 1'b1;
            if (wready === 1'b1) wh = 1'b1;
            bh = (bvalid === 1'b1);
            @(posedge aclk);
            if (ah) awvalid <= 1'b0;
            if (wh) wvalid <= 1'b0;
            if (bh) bready <= 1'b0;
        end
        // one spare edge so a next call never re-raises what this one just dropped
        @(posedge aclk);
        check("write_done", {31'h0, bh}, 32'h1);
    endtask

    task automatic axi_rd(input logic [5:0] a, input logic [33:0] e);
        int   n;
        logic ah;
        logic rh;
        rq.push_back(e);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        ah = 1'b0;
        rh = 1'b0;
        for (n = 0; n < 50 && !rh; n++)
        begin
            @(negedge aclk);
            if (arready === 1'b1) ah = 1'b1;
            rh = (rvalid === 1'b1);
            @(posedge aclk);
            if (ah) arvalid <= 1'b0;
            if (rh) rready <= 1'b0;
        end
        @(posedge aclk);
        check("read_done", {31'h0, rh}, 32'h1);
    endtask

    task automatic set_src(input int a, input int p);
        set_v <= 1'b1;
        set_a <= 16'(a);
        set_p <= 16'(p);
        @(posedge aclk);
        set_v <= 1'b0;
        repeat (3) @(posedge aclk);
    endtask

    task automatic run_pwm(input int n, input logic [31:0] hc);
        int k;
        repeat (n) pq.push_back(hc);
        enable <= 1'b1;
        for (k = 0; k < 3000 && pq.size() > 0; k++) @(posedge aclk);
        enable <= 1'b0;
        repeat (5) @(posedge aclk);
        @(negedge aclk);
        check("idle_low", {31'h0, pulse_out}, 32'h0);
        check("pulses_left", 32'(pq.size()), 32'h0);
        pq.delete();
        @(posedge aclk);
    endtask

    // full and zero duty never make a falling edge, so watch the level itself
    task automatic hold_pwm(input logic lvl);
        int   k;
        logic ok;
        enable <= 1'b1;
        repeat (6) @(posedge aclk);
        ok = 1'b1;
        for (k = 0; k < 60; k++)
        begin
            @(negedge aclk);
            if (pulse_out !== lvl) ok = 1'b0;
        end
        check("hold_level", {31'h0, ok}, 32'h1);
        @(posedge aclk);
        enable <= 1'b0;
        repeat (6) @(posedge aclk);
    endtask

    task automatic pwm_case(input int a, g, o, lo, hi, per, ctrl, live);
        int w;
        int t;
        int u;
        int h;
        axi_wr(ADDR_GAIN, 32'(g), RESP_OKAY);
        axi_wr(ADDR_OFFSET, 32'(o), RESP_OKAY);
        axi_wr(ADDR_RLOW, 32'(lo), RESP_OKAY);
        axi_wr(ADDR_RHIGH, 32'(hi), RESP_OKAY);
        axi_wr(ADDR_PERIOD, 32'(per), RESP_OKAY);
        axi_wr(ADDR_CTRL, 32'(ctrl), RESP_OKAY);
        set_src(a, live);
        w = a * g / 100 + o;
        t = (ctrl & 1) ? live : per;
        case ((ctrl >> CTRL_TB_LSB) & 3)
            0: u = T0;
            1: u = T1;
            2: u = T2;
            default: u = T3;
        endcase
        h = (w <= lo) ? 0 : (w >= hi) ? t : (w - lo) * t / (hi - lo);
        if (h == 0)
            hold_pwm(1'b0);
        else if (h == t)
            hold_pwm(1'b1);
        else
            run_pwm(3, 32'(h * u));
    endtask

    initial
    begin
        repeat (40000) @(posedge aclk);
        err_total++;
        $display("BAD watchdog expected finish seen hang");
        print_verdict();
    end

    initial
    begin : main
        int i;
        int g;
        int o;
        int a;
        void'($urandom(49));
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        for (i = 0; i < 6; i++) axi_rd(ra[i], {RESP_OKAY, rv[i]});
        axi_rd(6'h20, {RESP_SLVERR, 32'h0});
        axi_rd(ADDR_STATUS, {RESP_OKAY, 32'h0});
        axi_wr(6'h24, 32'h1, RESP_SLVERR);
        for (i = 0; i < 4; i++)
        begin
            g = int'($urandom_range(2000)) - 1000;
            o = int'($urandom_range(20000)) - 10000;
            a = int'($urandom_range(600)) - 300;
            axi_wr(ADDR_GAIN, 32'(g), RESP_OKAY);
            axi_wr(ADDR_OFFSET, 32'(o), RESP_OKAY);
            set_src(a, 0);
            axi_rd(ADDR_WORKING, {RESP_OKAY, 32'(a * g / 100 + o)});
        end
        pwm_case(500, 100, 0, 0, 1000, 4, 0, 0);
        pwm_case(300, 100, 0, 0, 1000, 10, 0, 0);
        pwm_case(100, 250, 50, 0, 1000, 4, 0, 0);
        pwm_case(0, 100, 0, -20000, 20000, 4, 0, 0);
        pwm_case(int'($urandom_range(749, 250)), 100, 0, 0, 1000, 4, 0, 0);
        pwm_case(500, 100, 0, 0, 1000, 4, 3 << CTRL_DEC_LSB, 0);
        pwm_case(250, 100, 0, 0, 1000, 4, 1, 8);
        for (i = 0; i < 4; i++) pwm_case(500, 100, 0, 0, 1000, 2, i << CTRL_TB_LSB, 0);
        pwm_case(0, 100, 0, 0, 1000, 4, 0, 0);
        pwm_case(1000, 100, 0, 0, 1000, 4, 0, 0);
        pwm_case(-50, 100, 0, 0, 1000, 4, 0, 0);
        print_verdict();
    end
endmodule
